//--- rtl/ccr_pkg.sv
// package: constants for the cpu control register block
package ccr_pkg;
  // program counter and address space
  localparam int PC_WIDTH = 20;
  localparam logic [19:0] RESET_VECTOR_LO_ADDR = 20'h00000;
  localparam logic [19:0] RESET_VECTOR_HI_ADDR = 20'h00001;
  // status word
  localparam logic [7:0] PSW_RESET = 8'h06;
  localparam int PSW_IE_BIT = 7;
  localparam int PSW_Z_BIT = 6;
  localparam int PSW_BANK_SELECT_HI_BIT = 5;
  localparam int PSW_BANK_SELECT_LO_BIT = 3;
  localparam int PSW_IN_SERVICE_PRIO_HI_BIT = 2;
  localparam int PSW_IN_SERVICE_PRIO_LO_BIT = 1;
  // general register banks
  localparam logic [19:0] GPR_BASE = 20'hffee0;
  localparam logic [19:0] GPR_LAST = 20'hffeff;
  // short direct window
  localparam logic [19:0] SHORT_DIRECT_BYTE_OPERAND_BASE = 20'hffe20;
  localparam logic [19:0] SHORT_DIRECT_BYTE_OPERAND_LAST = 20'hfff1f;
  localparam logic [7:0] SHORT_DIRECT_BYTE_OPERAND_WRAP = 8'h20;
  // flash mirror select
  localparam logic [7:0] MIRROR_RESET = 8'h00;
  localparam logic [19:0] MIRROR_BASE = 20'hf0000;
  // stack operation codes
  typedef enum logic [1:0] {
    CCR_STK_NONE = 2'h0,
    CCR_STK_PUSH = 2'h1,
    CCR_STK_POP = 2'h2
  } ccr_stk_type;
endpackage

//--- rtl/ccr_short_direct_byte_operand.sv
// short direct address resolver
`timescale 1ns/1ps
module ccr_short_direct_byte_operand
  import ccr_pkg::*;
(
  input wire logic [7:0] i_offset,
  input wire logic [19:0] i_imm,
  input wire logic i_use_imm,
  output logic [19:0] o_addr,
  output logic o_in_range
);
  logic [15:0] low16;
  always_comb begin
    // 8-bit offsets 00..1f wrap to the top of the window
    if (i_offset < SHORT_DIRECT_BYTE_OPERAND_WRAP) begin
      low16 = {8'hff, i_offset};
    end else begin
      low16 = {8'hfe, i_offset};
    end
    if (i_use_imm) begin
      o_addr = {4'hf, i_imm[15:0]};
      o_in_range = (i_imm[19:16] == 4'hf || i_imm[19:16] == 4'h0)
        && ({4'hf, i_imm[15:0]} >= SHORT_DIRECT_BYTE_OPERAND_BASE)
        && ({4'hf, i_imm[15:0]} <= SHORT_DIRECT_BYTE_OPERAND_LAST);
    end else begin
      o_addr = {4'hf, low16};
      o_in_range = 1'b1;
    end
  end
endmodule // ccr_short_direct_byte_operand

//--- rtl/ccr_core.sv
// cpu control registers: program counter, status word, mirror select
`timescale 1ns/1ps
module ccr_core
  import ccr_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // reset vector fetch: bytes at addresses 0 and 1
  input wire logic i_vec_valid,
  input wire logic [7:0] i_vec_lo,
  input wire logic [7:0] i_vec_hi,
  // sequencing
  input wire logic i_advance,
  input wire logic [2:0] i_instr_len,
  input wire logic i_branch,
  input wire logic [19:0] i_branch_target,
  // status word operations
  input wire logic i_di_instr,
  input wire logic i_ei_instr,
  input wire logic i_irq_req,
  input wire logic i_irq_allowed,
  input wire logic i_result_valid,
  input wire logic [15:0] i_result,
  input wire logic i_bank_sel_instr,
  input wire logic [1:0] i_bank_num,
  input wire ccr_stk_type i_psw_stack,
  input wire logic [7:0] i_psw_pop_data,
  input wire logic i_psw_write,
  input wire logic [7:0] i_psw_wdata,
  // mirror select writes
  input wire logic i_mirror_wr_byte,
  input wire logic i_mirror_wr_bit,
  input wire logic [2:0] i_mirror_bit_idx,
  input wire logic [7:0] i_mirror_wdata,
  // short direct
  input wire logic [7:0] i_short_direct_byte_operand_offset,
  input wire logic [19:0] i_short_direct_byte_operand_imm,
  input wire logic i_short_direct_byte_operand_use_imm,
  input wire logic i_short_direct_byte_operand_pair,
  output logic [19:0] o_program_counter,
  output logic [7:0] o_program_status_word,
  output logic [7:0] o_flash_mirror_select,
  output logic o_pc_ready,
  output logic o_irq_accept,
  output logic [19:0] o_bank_base,
  output logic o_fetch_fault,
  output logic [7:0] o_psw_push_data,
  output logic o_psw_push,
  output logic [19:0] o_short_direct_byte_operand_addr,
  output logic o_short_direct_byte_operand_fault
);
  // ****************************************
  // address helpers
  // ****************************************
  function automatic logic in_gpr(input logic [19:0] a);
    in_gpr = (a >= GPR_BASE) && (a <= GPR_LAST);
  endfunction

  logic [19:0] sd_addr;
  logic sd_ok;
  ccr_short_direct_byte_operand u_short_direct_byte_operand (
    .i_offset(i_short_direct_byte_operand_offset),
    .i_imm(i_short_direct_byte_operand_imm),
    .i_use_imm(i_short_direct_byte_operand_use_imm),
    .o_addr(sd_addr),
    .o_in_range(sd_ok)
  );

  // ****************************************
  // program counter
  // ****************************************
  logic [19:0] program_counter, next_program_counter;
  logic pc_ready, next_pc_ready;
  always_comb begin
    next_program_counter = program_counter;
    next_pc_ready = pc_ready;
    if (!pc_ready) begin
      if (i_vec_valid) begin
        // only a 16-bit vector exists, upper bits start at zero
        next_program_counter = {4'h0, i_vec_hi, i_vec_lo};
        next_pc_ready = 1'b1;
      end
    end else if (i_branch) begin
      next_program_counter = i_branch_target;
    end else if (i_advance) begin
      next_program_counter = program_counter + {17'h0, i_instr_len};
    end
  end
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      program_counter <= 20'h00000;
      pc_ready <= 1'b0;
    end else begin
      program_counter <= next_program_counter;
      pc_ready <= next_pc_ready;
    end
  end

  // ****************************************
  // status word
  // ****************************************
  logic [7:0] program_status_word, next_psw;
  logic accept, next_accept;
  logic push, next_push;
  always_comb begin
    next_psw = program_status_word;
    // ie gates every maskable request
    next_accept = i_irq_req && program_status_word[PSW_IE_BIT] && i_irq_allowed;
    next_push = next_accept || (i_psw_stack == CCR_STK_PUSH);
    if (i_psw_write) begin
      next_psw = i_psw_wdata;
    end
    if (i_result_valid) begin
      next_psw[PSW_Z_BIT] = (i_result == 16'h0000);
    end
    if (i_bank_sel_instr) begin
      next_psw[PSW_BANK_SELECT_HI_BIT] = i_bank_num[1];
      next_psw[PSW_BANK_SELECT_LO_BIT] = i_bank_num[0];
    end
    if (i_ei_instr) begin
      next_psw[PSW_IE_BIT] = 1'b1;
    end
    // disable and acceptance win over enable
    if (i_di_instr || next_accept) begin
      next_psw[PSW_IE_BIT] = 1'b0;
    end
    if (i_psw_stack == CCR_STK_POP) begin
      next_psw = i_psw_pop_data;
    end
  end
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      program_status_word <= PSW_RESET;
      accept <= 1'b0;
      push <= 1'b0;
    end else begin
      program_status_word <= next_psw;
      accept <= next_accept;
      push <= next_push;
    end
  end

  // ****************************************
  // flash mirror select
  // ****************************************
  logic [7:0] mirror, next_mirror;
  always_comb begin
    next_mirror = mirror;
    if (i_mirror_wr_byte) begin
      next_mirror = i_mirror_wdata;
    end else if (i_mirror_wr_bit) begin
      next_mirror[i_mirror_bit_idx] = i_mirror_wdata[0];
    end
  end
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      mirror <= MIRROR_RESET;
    end else begin
      mirror <= next_mirror;
    end
  end

  // ****************************************
  // registered outputs
  // ****************************************
  logic [19:0] bank_base, short_direct_byte_operand_q;
  logic fetch_fault, short_direct_byte_operand_fault;
  logic [7:0] push_data;
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      bank_base <= GPR_BASE;
      fetch_fault <= 1'b0;
      short_direct_byte_operand_q <= SHORT_DIRECT_BYTE_OPERAND_BASE;
      short_direct_byte_operand_fault <= 1'b0;
      push_data <= PSW_RESET;
    end else begin
      // bank 0 sits at the top, banks step down by eight bytes
      bank_base <= GPR_BASE + {15'h0, 2'b11 -
        {next_psw[PSW_BANK_SELECT_HI_BIT], next_psw[PSW_BANK_SELECT_LO_BIT]}, 3'h0};
      fetch_fault <= next_pc_ready && in_gpr(next_program_counter);
      short_direct_byte_operand_q <= sd_addr;
      // odd pair addresses are flagged, not corrected
      short_direct_byte_operand_fault <= !sd_ok || (i_short_direct_byte_operand_pair && sd_addr[0]);
      push_data <= program_status_word;
    end
  end

  assign o_program_counter = program_counter;
  assign o_program_status_word = program_status_word;
  assign o_flash_mirror_select = mirror;
  assign o_pc_ready = pc_ready;
  assign o_irq_accept = accept;
  assign o_bank_base = bank_base;
  assign o_fetch_fault = fetch_fault;
  assign o_psw_push_data = push_data;
  assign o_psw_push = push;
  assign o_short_direct_byte_operand_addr = short_direct_byte_operand_q;
  assign o_short_direct_byte_operand_fault = short_direct_byte_operand_fault;

  // ****************************************
  // checks
  // ****************************************
  a_psw_reset: assert property (@(posedge i_clock)
    $past(i_sys_rst) |-> program_status_word == PSW_RESET)
    else $error("status word not 06h after reset");
  a_ie_gate: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    accept |-> $past(program_status_word[PSW_IE_BIT]))
    else $error("request accepted with ie clear");
  a_ie_clear: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    accept && !$past(i_psw_stack == CCR_STK_POP) |-> !program_status_word[PSW_IE_BIT])
    else $error("ie not cleared on acceptance");
  a_zero_flag: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    i_result_valid && i_psw_stack == CCR_STK_NONE
    |=> program_status_word[PSW_Z_BIT] == ($past(i_result) == 16'h0000))
    else $error("zero flag wrong");
  a_pc_advance: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    pc_ready && !i_branch && i_advance
    |=> program_counter == $past(program_counter) + $past(i_instr_len))
    else $error("pc did not advance by length");
  a_pc_branch: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    pc_ready && i_branch |=> program_counter == $past(i_branch_target))
    else $error("pc did not take branch");
  a_mirror_reset: assert property (@(posedge i_clock)
    $past(i_sys_rst) |-> mirror == MIRROR_RESET)
    else $error("mirror select not 00h after reset");
  a_short_direct_byte_operand_range: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    !short_direct_byte_operand_fault |-> short_direct_byte_operand_q >= SHORT_DIRECT_BYTE_OPERAND_BASE && short_direct_byte_operand_q <= SHORT_DIRECT_BYTE_OPERAND_LAST)
    else $error("short direct address out of window");
  a_bank_sel: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    i_bank_sel_instr && i_psw_stack == CCR_STK_NONE && !i_psw_write
    |=> {program_status_word[PSW_BANK_SELECT_HI_BIT], program_status_word[PSW_BANK_SELECT_LO_BIT]} == $past(i_bank_num))
    else $error("bank select not written");
  c_accept: cover property (@(posedge i_clock) accept);
  c_vector: cover property (@(posedge i_clock) !pc_ready ##1 pc_ready);
  c_pop: cover property (@(posedge i_clock) i_psw_stack == CCR_STK_POP);
  c_fault: cover property (@(posedge i_clock) fetch_fault);
endmodule // ccr_core

//--- test/ccr_tb_top.sv
// self-checking testbench for the cpu control register block
`timescale 1ns/1ps
module cpu_control_regs_addressing_tb_top;
  import ccr_pkg::*;
  logic i_clock, i_sys_rst, i_vec_valid, i_advance, i_branch;
  logic i_di_instr, i_ei_instr, i_irq_req, i_irq_allowed, i_result_valid;
  logic i_bank_sel_instr, i_psw_write, i_mirror_wr_byte, i_mirror_wr_bit;
  logic i_short_direct_byte_operand_use_imm, i_short_direct_byte_operand_pair;
  logic [7:0] i_vec_lo, i_vec_hi, i_psw_pop_data, i_psw_wdata;
  logic [7:0] i_mirror_wdata, i_short_direct_byte_operand_offset;
  logic [2:0] i_instr_len, i_mirror_bit_idx;
  logic [19:0] i_branch_target, i_short_direct_byte_operand_imm;
  logic [15:0] i_result;
  logic [1:0] i_bank_num;
  ccr_stk_type i_psw_stack;
  logic [19:0] o_program_counter, o_bank_base, o_short_direct_byte_operand_addr;
  logic [7:0] o_program_status_word, o_flash_mirror_select, o_psw_push_data;
  logic o_pc_ready, o_irq_accept, o_fetch_fault, o_psw_push, o_short_direct_byte_operand_fault;
  int errors, samples_checked, k;
  logic [19:0] pc, a;
  logic [7:0] program_status_word, mir, v;
  logic b;
  logic [3:0] tbl [6] = '{4'h3, 4'h8, 4'h2, 4'h3, 4'h8, 4'h4};

  ccr_core i_ccr_core (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
    .i_vec_valid(i_vec_valid), .i_vec_lo(i_vec_lo), .i_vec_hi(i_vec_hi),
    .i_advance(i_advance), .i_instr_len(i_instr_len), .i_branch(i_branch),
    .i_branch_target(i_branch_target), .i_di_instr(i_di_instr),
    .i_ei_instr(i_ei_instr), .i_irq_req(i_irq_req),
    .i_irq_allowed(i_irq_allowed), .i_result_valid(i_result_valid),
    .i_result(i_result), .i_bank_sel_instr(i_bank_sel_instr),
    .i_bank_num(i_bank_num), .i_psw_stack(i_psw_stack),
    .i_psw_pop_data(i_psw_pop_data), .i_psw_write(i_psw_write),
    .i_psw_wdata(i_psw_wdata), .i_mirror_wr_byte(i_mirror_wr_byte),
    .i_mirror_wr_bit(i_mirror_wr_bit), .i_mirror_bit_idx(i_mirror_bit_idx),
    .i_mirror_wdata(i_mirror_wdata), .i_short_direct_byte_operand_offset(i_short_direct_byte_operand_offset),
    .i_short_direct_byte_operand_imm(i_short_direct_byte_operand_imm), .i_short_direct_byte_operand_use_imm(i_short_direct_byte_operand_use_imm),
    .i_short_direct_byte_operand_pair(i_short_direct_byte_operand_pair), .o_program_counter(o_program_counter),
    .o_program_status_word(o_program_status_word),
    .o_flash_mirror_select(o_flash_mirror_select), .o_pc_ready(o_pc_ready),
    .o_irq_accept(o_irq_accept), .o_bank_base(o_bank_base),
    .o_fetch_fault(o_fetch_fault), .o_psw_push_data(o_psw_push_data),
    .o_psw_push(o_psw_push), .o_short_direct_byte_operand_addr(o_short_direct_byte_operand_addr),
    .o_short_direct_byte_operand_fault(o_short_direct_byte_operand_fault));

  // ****************************************
  // expectations and checks
  // ****************************************
  function automatic logic [19:0] bank_exp(input logic [1:0] n);
    return GPR_BASE + 20'((3 - n) * 8);
  endfunction

  // offsets below 20h wrap to the top of the window
  function automatic logic [19:0] short_direct_byte_operand_exp(input logic [7:0] off,
      input logic [19:0] imm, input logic use_imm);
    if (use_imm) return {4'hf, imm[15:0]};
    return (off < SHORT_DIRECT_BYTE_OPERAND_WRAP) ? {12'hfff, off} : {12'hffe, off};
  endfunction

  task automatic chk(input string what, input logic [19:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // pulses last one cycle: cleared on the edge that samples them
  task automatic fin;
    @(posedge i_clock);
    {i_vec_valid, i_advance, i_branch, i_di_instr, i_ei_instr} <= '0;
    {i_irq_req, i_result_valid, i_bank_sel_instr, i_psw_write} <= '0;
    {i_mirror_wr_byte, i_mirror_wr_bit} <= '0;
    i_psw_stack <= CCR_STK_NONE;
    #1;
  endtask

  task automatic give_verdict;
    if (errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ****************************************
  // clock, watchdog and tests
  // ****************************************
  initial begin
    i_clock = 0;
    forever #20 i_clock = ~i_clock;
  end

  initial begin
    #(4000 * 40);
    errors++;
    give_verdict;
  end

  initial begin
    {i_vec_valid, i_advance, i_branch, i_di_instr, i_ei_instr, i_irq_req,
     i_irq_allowed, i_result_valid, i_bank_sel_instr, i_psw_write,
     i_mirror_wr_byte, i_mirror_wr_bit, i_short_direct_byte_operand_use_imm, i_short_direct_byte_operand_pair,
     i_vec_lo, i_vec_hi, i_psw_pop_data, i_psw_wdata, i_mirror_wdata,
     i_short_direct_byte_operand_offset, i_instr_len, i_mirror_bit_idx, i_branch_target,
     i_short_direct_byte_operand_imm, i_result, i_bank_num} = '0;
    i_psw_stack = CCR_STK_NONE;
    i_sys_rst = 1;
    k = $urandom(32'hd590a829);
    repeat (2) @(posedge i_clock);
    // advance alongside the vector must be ignored before ready
    a = 20'($urandom);
    i_sys_rst <= 0;
    {i_vec_valid, i_advance} <= 2'h3;
    {i_vec_hi, i_vec_lo} <= a[15:0];
    i_instr_len <= 3'h4;
    #1;
    chk("pc", 20'h0, o_program_counter);
    chk("psw", PSW_RESET, o_program_status_word);
    chk("mirror", MIRROR_RESET, o_flash_mirror_select);
    chk("ready", 20'h0, o_pc_ready);
    fin;
    pc = {4'h0, a[15:0]};
    chk("pc", pc, o_program_counter);
    for (k = 0; k < 24; k++) begin
      @(posedge i_clock);
      v = 8'($urandom_range(1, 7));
      i_advance <= 1;
      i_instr_len <= v[2:0];
      if (k % 3 == 0) begin
        a = (k % 2) ? GPR_BASE + 20'($urandom_range(0, 31)) : 20'($urandom);
        i_branch <= 1;
        i_branch_target <= a;
      end
      pc = (k % 3 == 0) ? a : pc + 20'(v);
      fin;
      chk("pc", pc, o_program_counter);
      chk("fault", 20'(pc >= GPR_BASE && pc <= GPR_LAST), o_fetch_fault);
    end
    program_status_word = PSW_RESET;
    for (k = 0; k < 8; k++) begin
      @(posedge i_clock);
      {i_result_valid, i_bank_sel_instr} <= 2'h3;
      i_result <= (k % 2) ? 16'h0 : 16'($urandom_range(1, 65535));
      i_bank_num <= k[1:0];
      program_status_word[PSW_Z_BIT] = k[0];
      {program_status_word[PSW_BANK_SELECT_HI_BIT], program_status_word[PSW_BANK_SELECT_LO_BIT]} = k[1:0];
      fin;
      chk("psw", program_status_word, o_program_status_word);
      chk("bank", bank_exp(k[1:0]), o_bank_base);
    end
    for (k = 0; k < 6; k++) begin
      @(posedge i_clock);
      {i_ei_instr, i_di_instr, i_irq_req, i_irq_allowed} <= tbl[k];
      v = program_status_word;
      b = program_status_word[PSW_IE_BIT] & tbl[k][1] & tbl[k][0];
      if (tbl[k][3]) program_status_word[PSW_IE_BIT] = 1;
      if (tbl[k][2] | b) program_status_word[PSW_IE_BIT] = 0;
      fin;
      chk("accept", 20'(b), o_irq_accept);
      chk("psw", program_status_word, o_program_status_word);
      chk("push", 20'(b), o_psw_push);
      if (b) chk("pushed", v, o_psw_push_data);
    end
    @(posedge i_clock);
    i_psw_stack <= CCR_STK_PUSH;
    fin;
    chk("push", 20'h1, o_psw_push);
    chk("pushed", program_status_word, o_psw_push_data);
    @(posedge i_clock);
    program_status_word = 8'($urandom);
    i_psw_stack <= CCR_STK_POP;
    i_psw_pop_data <= program_status_word;
    fin;
    chk("psw", program_status_word, o_program_status_word);
    mir = MIRROR_RESET;
    for (k = 0; k < 9; k++) begin
      @(posedge i_clock);
      v = 8'($urandom);
      i_mirror_wdata <= v;
      i_mirror_bit_idx <= k[2:0];
      if (k == 0) i_mirror_wr_byte <= 1;
      else i_mirror_wr_bit <= 1;
      if (k == 0) mir = v;
      else mir[k[2:0]] = v[0];
      fin;
      chk("mirror", mir, o_flash_mirror_select);
    end
    // corner offsets first: lowest window byte and the wrap point
    for (k = 0; k < 40; k++) begin
      @(posedge i_clock);
      v = (k < 4 && !k[0]) ? (k ? 8'h1f : 8'h20) : 8'($urandom);
      a = {(k % 4 == 3) ? 4'h5 : (k % 8 == 1) ? 4'h0 : 4'hf,
           16'hfe20 + 16'($urandom_range(0, 255))};
      i_short_direct_byte_operand_offset <= v;
      i_short_direct_byte_operand_imm <= a;
      i_short_direct_byte_operand_use_imm <= k[0];
      i_short_direct_byte_operand_pair <= (k % 5 == 0);
      b = (k[0] && a[19:16] == 4'h5);
      b = b | ((k % 5 == 0) & short_direct_byte_operand_exp(v, a, k[0]) & 20'h1) != 0;
      fin;
      chk("short_direct_byte_operand_fault", 20'(b), o_short_direct_byte_operand_fault);
      if (!b) chk("short_direct_byte_operand", short_direct_byte_operand_exp(v, a, k[0]), o_short_direct_byte_operand_addr);
    end
    give_verdict;
  end
endmodule // cpu_control_regs_addressing_tb_top
